// ==== hdl/loader_regs.vh ====
// Constants shared by the configuration loader files.
`ifndef LOADER_REGS_VH
`define LOADER_REGS_VH

// ----------------------------------------------------------------------------
// Mode codes, ordered mode_select_0, mode_select_1, mode_select_2
// ----------------------------------------------------------------------------
`define MODE_MSER       3'h0
`define MODE_MPAR_UP    3'h1
`define MODE_MPAR_DN    3'h3
`define MODE_PERIPH     3'h5
`define MODE_SLAVE      3'h7

// ----------------------------------------------------------------------------
// Address start points for the parallel master modes
// ----------------------------------------------------------------------------
`define ADDR_UP_START   16'h0000
`define ADDR_DN_START   16'hFFFF
`define ADDR_STEP       16'h0001

// ----------------------------------------------------------------------------
// Bitstream lengths and timing
// ----------------------------------------------------------------------------
`define BITS_SMALL      12040
`define BITS_LARGE      17880
`define CLK_MHZ         20
`define FILTER_US       4
`define CONFIG_CLOCK_HALF       8
`define BYTE_LAST       3'h7

`endif

// ==== hdl/pin_sync.v ====
// Two-stage synchroniser for a bundle of pin inputs.
module pin_sync #(
  parameter WIDTH = 20
) (
  // Clock, reset, enable
  input  wire             clk,
  input  wire             reset,
  input  wire             ce,
  // Data
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta;

  // The first stage is read by the second stage only.
  always @(posedge clk) begin
    if (reset) begin
      meta <= {WIDTH{1'b1}};
      q    <= {WIDTH{1'b1}};
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ==== hdl/sram_fabric_config_loader.v ====
// Power-up configuration loader with five load modes, done line and readback.
//
// How it works
// - Mode pins are latched on the rising edge of the pin reset.
// - Codes 000 serial master, 001/011 parallel up/down, 101 peripheral, 111 slave.
// - Mode pin 2 pull-up is enabled throughout configuration.
// - Done line driven low while loading, released afterwards.
// - Done line released one configuration bit before the last bit.
// - Outside low on done, longer than the filter, restarts configuration.
// - Done held low after loading suppresses reconfiguration and delays operation.
// - Pin reset during configuration aborts and returns to initialisation.
// - Pin reset after configuration only clears user state, no reload.
// - Power-down floats I/O, drives done low, clears state, keeps configuration.
// - Slave mode takes one data bit per configuration clock rising edge.
// - Daisy-chain output changes on configuration clock rising edges, or on write_strobe_n rising edges in peripheral mode.
// - Configuration clock driven in all modes except slave.
// - Readback started by trigger, clocked by config_clock, bits on readback_out.
// - Read strobe low while data expected, high while address changes.
// - High/low loading pins hold one/zero during configuration, then user I/O.
// - Pull-ups on idle I/O during configuration, removed afterwards.
// - Peripheral write strobes accepted only with selects 0, 0, 1.
// - Peripheral mode takes one bit per rising edge of write_strobe_n.
// - Parallel master drives 16-bit address from 0000 up or FFFF down.
// - Parallel master keeps counting and forwarding while done line held low.
// - Configuration completes only after the exact full bitstream length.
//
// The register offsets and the plain strobed port were left to the implementer.
`include "loader_regs.vh"

module sram_fabric_config_loader #(
  parameter BIT_LEN   = `BITS_SMALL,
  parameter CNT_W     = 15,
  parameter CONFIG_CLOCK_HALF = `CONFIG_CLOCK_HALF,
  parameter FILTER_US = `FILTER_US,
  parameter KEEP_W    = 16
) (
  // Clock, reset, enable
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  // Device reset and power-down pins
  input  wire        reset_pin_n,
  input  wire        low_power_hold_n,
  // Mode pins
  input  wire        mode_select_0,
  input  wire        mode_select_1,
  input  wire        mode_select_2,
  output reg         mode2_pullup_en,
  // Done / program open-drain line
  input  wire        done_program_in,
  output reg         done_program_out,
  output reg         done_program_oe_n,
  // Configuration clock two-way pin
  input  wire        config_clock_in,
  output reg         config_clock_out,
  output reg         config_clock_oe_n,
  // Serial data
  input  wire        serial_config_in,
  output reg         serial_config_out,
  output reg         readback_out,
  // Peripheral port
  input  wire        select_n0,
  input  wire        select_n1,
  input  wire        select_high2,
  input  wire        write_strobe_n,
  // Parallel memory port
  input  wire [7:0]  memory_byte_in,
  output reg  [15:0] memory_addr,
  output reg         memory_addr_oe_n,
  output reg         read_strobe,
  // Loading indicators and pin control
  input  wire        user_high_pin,
  input  wire        user_low_pin,
  output reg         high_while_loading,
  output reg         low_while_loading,
  output reg         io_pullup_en,
  output reg         io_hiz,
  // Status towards user logic
  output reg         functional,
  output reg         user_clear
);

  // --------------------------------------------------------------------------
  // States and derived counts
  // --------------------------------------------------------------------------
  localparam ST_INIT  = 3'h0;
  localparam ST_LOAD  = 3'h1;
  localparam ST_HOLD  = 3'h2;
  localparam ST_RUN   = 3'h3;
  localparam ST_PDOWN = 3'h4;

  localparam PH_ADDR  = 2'h0;
  localparam PH_DATA  = 2'h1;
  localparam PH_SHIFT = 2'h2;

  localparam [CNT_W-1:0] LAST_BIT    = BIT_LEN - 1;
  localparam [CNT_W-1:0] RELEASE_BIT = BIT_LEN - 2;
  localparam [15:0]      FILTER_CYC  = FILTER_US * `CLK_MHZ;
  localparam [7:0]       HALF_LAST   = CONFIG_CLOCK_HALF - 1;
  localparam [7:0]       KEEP_CNT    = KEEP_W;

  function is_mpar;
    input [2:0] m;
    begin
      is_mpar = (m == `MODE_MPAR_UP) || (m == `MODE_MPAR_DN);
    end
  endfunction

  function is_valid_mode;
    input [2:0] m;
    begin
      is_valid_mode = (m == `MODE_MSER) || is_mpar(m) ||
                      (m == `MODE_PERIPH) || (m == `MODE_SLAVE);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  wire [19:0] raw_pins = {reset_pin_n, mode_select_0, mode_select_1, mode_select_2,
                          done_program_in, low_power_hold_n, serial_config_in,
                          config_clock_in, select_n0, select_n1, select_high2,
                          write_strobe_n, memory_byte_in};
  wire [19:0] s;

  pin_sync #(
    .WIDTH (20)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .d     (raw_pins),
    .q     (s)
  );

  wire       s_rst_n  = s[19];
  wire       s_m0     = s[18];
  wire       s_m1     = s[17];
  wire       s_m2     = s[16];
  wire       s_done   = s[15];
  wire       s_lph_n  = s[14];
  wire       s_din    = s[13];
  wire       s_config_clock   = s[12];
  wire       s_cs0_n  = s[11];
  wire       s_cs1_n  = s[10];
  wire       s_cs2    = s[9];
  wire       s_wrt_n  = s[8];
  wire [7:0] s_byte   = s[7:0];
  // The trigger shares the mode_select_0 pin once the device is running.
  wire       readback_trigger = s_m0;

  reg        p_rst_n;
  reg        p_config_clock;
  reg        p_wrt_n;
  reg        p_trig;

  // --------------------------------------------------------------------------
  // Internal configuration clock
  // --------------------------------------------------------------------------
  reg  [7:0] div_cnt;
  reg        config_clock_int;
  wire       tick = (div_cnt == HALF_LAST) && !config_clock_int;

  always @(posedge clk) begin
    if (reset) begin
      div_cnt  <= 8'h00;
      config_clock_int <= 1'b0;
    end else if (ce) begin
      if (div_cnt == HALF_LAST) begin
        div_cnt  <= 8'h00;
        config_clock_int <= ~config_clock_int;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Core state
  // --------------------------------------------------------------------------
  reg [2:0]        state;
  reg [2:0]        mode;
  reg [CNT_W-1:0]  bit_cnt;
  reg [15:0]       filt_cnt;
  reg [KEEP_W-1:0] cfg_keep;
  reg [KEEP_W-1:0] rb_shift;
  reg [7:0]        rb_cnt;
  reg [1:0]        fetch_phase;
  reg [2:0]        bit_idx;
  reg [7:0]        byte_reg;
  reg              bit_evt;
  reg              bit_val;

  wire loading = (state == ST_INIT) || (state == ST_LOAD) || (state == ST_HOLD);
  wire moving  = (state == ST_LOAD) || (state == ST_HOLD);
  wire sel_ok  = !s_cs0_n && !s_cs1_n && s_cs2;
  // While waiting for the reset pin, the start address follows the pins that are about to be latched.
  wire [2:0] start_mode = (state == ST_INIT) ? {s_m0, s_m1, s_m2} : mode;

  // Source of the next configuration bit for the latched mode.
  always @* begin
    bit_evt = 1'b0;
    bit_val = s_din;
    case (mode)
      `MODE_SLAVE:  bit_evt = s_config_clock && !p_config_clock;
      `MODE_PERIPH: bit_evt = s_wrt_n && !p_wrt_n && sel_ok;
      `MODE_MSER:   bit_evt = tick;
      default: begin
        bit_evt = tick && (fetch_phase == PH_SHIFT);
        bit_val = byte_reg[bit_idx];
      end
    endcase
    if (!moving) begin
      bit_evt = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Parallel memory fetch
  // --------------------------------------------------------------------------
  // The address only moves while read_strobe is high, so the memory always
  // sees a stable address for a full internal clock before data is taken.
  always @(posedge clk) begin
    if (reset) begin
      fetch_phase <= PH_ADDR;
      bit_idx     <= 3'h0;
      byte_reg    <= 8'h00;
      memory_addr <= `ADDR_UP_START;
      read_strobe <= 1'b1;
    end else if (ce) begin
      if (!moving || !is_mpar(mode)) begin
        fetch_phase <= PH_ADDR;
        bit_idx     <= 3'h0;
        read_strobe <= 1'b1;
        memory_addr <= (start_mode == `MODE_MPAR_DN) ? `ADDR_DN_START : `ADDR_UP_START;
      end else if (tick) begin
        case (fetch_phase)
          PH_ADDR: begin
            read_strobe <= 1'b0;
            fetch_phase <= PH_DATA;
          end
          PH_DATA: begin
            byte_reg    <= s_byte;
            bit_idx     <= 3'h0;
            fetch_phase <= PH_SHIFT;
          end
          default: begin
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == `BYTE_LAST) begin
              fetch_phase <= PH_ADDR;
              read_strobe <= 1'b1;
              if (mode == `MODE_MPAR_DN) begin
                memory_addr <= memory_addr - `ADDR_STEP;
              end else begin
                memory_addr <= memory_addr + `ADDR_STEP;
              end
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration sequence
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      state             <= ST_INIT;
      mode              <= `MODE_SLAVE;
      bit_cnt           <= {CNT_W{1'b0}};
      filt_cnt          <= 16'h0000;
      cfg_keep          <= {KEEP_W{1'b0}};
      done_program_out  <= 1'b0;
      done_program_oe_n <= 1'b0;
      serial_config_out <= 1'b1;
      p_rst_n           <= 1'b1;
      p_config_clock            <= 1'b1;
      p_wrt_n           <= 1'b1;
    end else if (ce) begin
      p_rst_n <= s_rst_n;
      p_config_clock  <= s_config_clock;
      p_wrt_n <= s_wrt_n;
      case (state)
        ST_INIT: begin
          done_program_oe_n <= 1'b0;
          bit_cnt           <= {CNT_W{1'b0}};
          serial_config_out <= 1'b1;
          if (s_rst_n && !p_rst_n) begin
            mode <= {s_m0, s_m1, s_m2};
            if (is_valid_mode({s_m0, s_m1, s_m2})) begin
              state <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          if (!s_rst_n) begin
            state <= ST_INIT;
          end else if (bit_evt) begin
            bit_cnt  <= bit_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            cfg_keep <= {bit_val, cfg_keep[KEEP_W-1:1]};
            if (bit_cnt == RELEASE_BIT) begin
              done_program_oe_n <= 1'b1;
            end
            if (bit_cnt == LAST_BIT) begin
              done_program_oe_n <= 1'b1;
              state             <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          // Own image is complete; bits now pass down the chain.
          if (!s_rst_n) begin
            state <= ST_INIT;
          end else if (s_done) begin
            state <= ST_RUN;
          end else if (bit_evt) begin
            serial_config_out <= bit_val;
          end
          filt_cnt <= 16'h0000;
        end
        ST_RUN: begin
          if (!s_lph_n) begin
            state             <= ST_PDOWN;
            done_program_oe_n <= 1'b0;
          end else if (!s_done && s_rst_n) begin
            if (filt_cnt == FILTER_CYC - 16'h0001) begin
              filt_cnt          <= 16'h0000;
              done_program_oe_n <= 1'b0;
              bit_cnt           <= {CNT_W{1'b0}};
              serial_config_out <= 1'b1;
              state             <= ST_LOAD;
            end else begin
              filt_cnt <= filt_cnt + 16'h0001;
            end
          end else begin
            filt_cnt <= 16'h0000;
          end
        end
        default: begin
          filt_cnt <= 16'h0000;
          if (s_lph_n) begin
            done_program_oe_n <= 1'b1;
            state             <= ST_RUN;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Readback
  // --------------------------------------------------------------------------
  // Only the last KEEP_W bits of the image are kept; the full image lives in
  // the fabric itself and is outside this block.
  always @(posedge clk) begin
    if (reset) begin
      rb_shift     <= {KEEP_W{1'b0}};
      rb_cnt       <= 8'h00;
      readback_out <= 1'b0;
      p_trig       <= 1'b0;
    end else if (ce) begin
      p_trig <= readback_trigger;
      if (state != ST_RUN) begin
        rb_cnt <= 8'h00;
      end else if (readback_trigger && !p_trig && (rb_cnt == 8'h00)) begin
        rb_shift <= cfg_keep;
        rb_cnt   <= KEEP_CNT;
      end else if ((rb_cnt != 8'h00) && s_config_clock && !p_config_clock) begin
        readback_out <= rb_shift[0];
        rb_shift     <= {1'b0, rb_shift[KEEP_W-1:1]};
        rb_cnt       <= rb_cnt - 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin control outputs
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      mode2_pullup_en    <= 1'b1;
      config_clock_out   <= 1'b0;
      config_clock_oe_n  <= 1'b1;
      memory_addr_oe_n   <= 1'b1;
      high_while_loading <= 1'b1;
      low_while_loading  <= 1'b0;
      io_pullup_en       <= 1'b1;
      io_hiz             <= 1'b0;
      functional         <= 1'b0;
      user_clear         <= 1'b1;
    end else if (ce) begin
      mode2_pullup_en    <= loading;
      config_clock_out   <= config_clock_int;
      config_clock_oe_n  <= !(moving && (mode != `MODE_SLAVE));
      memory_addr_oe_n   <= !(moving && is_mpar(mode));
      high_while_loading <= loading ? 1'b1 : user_high_pin;
      low_while_loading  <= loading ? 1'b0 : user_low_pin;
      io_pullup_en       <= loading;
      io_hiz             <= (state == ST_PDOWN);
      functional         <= (state == ST_RUN) && s_rst_n;
      user_clear         <= (state == ST_PDOWN) || ((state == ST_RUN) && !s_rst_n);
    end
  end

endmodule

// ==== tb/loader_chk.sv ====
// Port-level checker for the configuration loader.
module loader_chk #(
  parameter FILTER_US = 4
) (
  input wire        clk,
  input wire        reset,
  input wire        low_power_hold_n,
  input wire        mode2_pullup_en,
  input wire        done_program_in,
  input wire        done_program_oe_n,
  input wire        config_clock_oe_n,
  input wire [15:0] memory_addr,
  input wire        memory_addr_oe_n,
  input wire        read_strobe,
  input wire        high_while_loading,
  input wire        low_while_loading,
  input wire        io_pullup_en,
  input wire        io_hiz,
  input wire        functional,
  input wire        user_clear
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FILT_CLK = FILTER_US * 20;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Length of the current low on the done line, to judge the noise filter.
  logic [15:0] low_cnt;
  always @(posedge clk) begin
    low_cnt <= (reset || done_program_in) ? 16'h0000 : low_cnt + 16'h0001;
  end

  loading_pins_a:
    assert property (mode2_pullup_en && $past(mode2_pullup_en) |-> high_while_loading && !low_while_loading)
    else $error("loading indicators wrong while configuring");
  done_release_a:
    assert property (functional |-> $past(done_program_oe_n)) else $error("done pulled low while running");
  start_together_a:
    assert property ($rose(functional) && !$past(io_hiz) |-> $past(done_program_in, 2))
    else $error("started with done line low");
  config_clock_drive_a:
    assert property (!config_clock_oe_n |-> mode2_pullup_en && !functional) else $error("clock driven outside load");
  pdown_state_a:
    assert property (io_hiz && !low_power_hold_n |-> !done_program_oe_n && !functional && user_clear)
    else $error("power-down state wrong");
  pdown_entry_a:
    assert property ($fell(low_power_hold_n) && functional |-> ##[1:6] io_hiz) else $error("power-down not entered");
  addr_step_a:
    assert property (!memory_addr_oe_n && $past(!memory_addr_oe_n) && $changed(memory_addr)
      |-> memory_addr == $past(memory_addr) + 16'h0001 || memory_addr == $past(memory_addr) - 16'h0001)
    else $error("address jumped");
  strobe_addr_a:
    assert property (!read_strobe |-> $stable(memory_addr)) else $error("address moved with strobe low");
  noise_filter_a:
    assert property ($fell(done_program_oe_n) && $past(functional) && low_power_hold_n |-> low_cnt >= FILT_CLK)
    else $error("reload before filter delay");
  run_user_a:
    assert property (functional |-> !user_clear && !io_pullup_en) else $error("user state cleared while running");

  cover property ($rose(functional));
  cover property ($rose(io_hiz));
  cover property (!memory_addr_oe_n && $changed(memory_addr));
endmodule

bind sram_fabric_config_loader loader_chk #(.FILTER_US(FILTER_US)) i_chk (
  .clk(clk), .reset(reset), .low_power_hold_n(low_power_hold_n), .mode2_pullup_en(mode2_pullup_en),
  .done_program_in(done_program_in), .done_program_oe_n(done_program_oe_n),
  .config_clock_oe_n(config_clock_oe_n), .memory_addr(memory_addr), .memory_addr_oe_n(memory_addr_oe_n),
  .read_strobe(read_strobe), .high_while_loading(high_while_loading), .low_while_loading(low_while_loading),
  .io_pullup_en(io_pullup_en), .io_hiz(io_hiz), .functional(functional), .user_clear(user_clear)
);

// ==== tb/config_source.sv ====
// Far-side model: serial source with its own clock and a byte-wide memory.
module config_source (
  // Frame control
  input  wire         start,
  input  wire  [15:0] nbits,
  output logic        busy,
  // Serial link
  output logic        link_clk,
  output logic        link_data,
  // Byte-wide memory
  input  wire  [15:0] memory_addr,
  input  wire         read_strobe,
  output logic [7:0]  memory_byte_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sent;
  initial begin
    busy = 1'b0;
    link_clk = 1'b0;
    link_data = 1'b0;
  end

  // The clock stands low between frames; the data line flips so a stale bit is never taken as good.
  always @(posedge start) begin
    busy = 1'b1;
    for (sent = 16'h0000; sent < nbits; sent++) begin
      link_data = sent[0] ^ sent[2];
      #200;
      link_clk = 1'b1;
      #200;
      link_clk = 1'b0;
    end
    link_data = ~link_data;
    busy = 1'b0;
  end

  // Data are valid only while the strobe is low; otherwise the inverse shows.
  assign memory_byte_in = (memory_addr[7:0] ^ 8'h5A) ^ {8{read_strobe}};
endmodule

// ==== tb/sram_fabric_config_loader_tb.sv ====
// Self-checking bench for the configuration loader.
module sram_fabric_config_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BITS = 40;
  localparam int HALF = 2;
  logic        clk, reset, reset_pin_n, low_power_hold_n, write_strobe_n, ext_low, start;
  logic        select_n0, select_n1, select_high2, user_high_pin, user_low_pin;
  logic [2:0]  mode;
  logic [15:0] nbits, a0, n;
  logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7, 3'h2};
  wire         busy, link_clk, link_data, done_w, config_clock_w, mode2_pullup_en, done_program_oe_n;
  wire         config_clock_out, config_clock_oe_n, memory_addr_oe_n, read_strobe, high_while_loading;
  wire         low_while_loading, io_pullup_en, io_hiz, functional, user_clear;
  wire [7:0]   mem_byte;
  wire [15:0]  memory_addr;
  int          error_cnt = 0;
  int          checked = 0;

  // ----------------------------------------------------------------------------
  // Pins: the done line has a pull-up, so it is low only when someone pulls it.
  // ----------------------------------------------------------------------------
  assign done_w = done_program_oe_n & ~ext_low;
  assign config_clock_w = config_clock_oe_n ? link_clk : config_clock_out;

  config_source i_src (.start(start), .nbits(nbits), .busy(busy), .link_clk(link_clk), .link_data(link_data),
    .memory_addr(memory_addr), .read_strobe(read_strobe), .memory_byte_in(mem_byte));

  sram_fabric_config_loader #(.BIT_LEN(BITS), .CONFIG_CLOCK_HALF(HALF)) i_dut (
    .clk(clk), .reset(reset), .ce(1'b1), .reset_pin_n(reset_pin_n), .low_power_hold_n(low_power_hold_n),
    .mode_select_0(mode[2]), .mode_select_1(mode[1]), .mode_select_2(mode[0]), .mode2_pullup_en(mode2_pullup_en),
    .done_program_in(done_w), .done_program_out(), .done_program_oe_n(done_program_oe_n),
    .config_clock_in(config_clock_w), .config_clock_out(config_clock_out), .config_clock_oe_n(config_clock_oe_n),
    .serial_config_in(link_data), .serial_config_out(), .readback_out(), .select_n0(select_n0),
    .select_n1(select_n1), .select_high2(select_high2), .write_strobe_n(write_strobe_n),
    .memory_byte_in(mem_byte), .memory_addr(memory_addr), .memory_addr_oe_n(memory_addr_oe_n),
    .read_strobe(read_strobe), .user_high_pin(user_high_pin), .user_low_pin(user_low_pin),
    .high_while_loading(high_while_loading), .low_while_loading(low_while_loading),
    .io_pullup_en(io_pullup_en), .io_hiz(io_hiz), .functional(functional), .user_clear(user_clear));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic boot(input logic [2:0] m);
    mode <= m;
    reset_pin_n <= 1'b0;
    cyc(4);
    reset_pin_n <= 1'b1;
    cyc(6);
  endtask

  task automatic frame(input logic [15:0] k);
    nbits <= k;
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    cyc(1);
    for (int i = 0; i < 4000 && busy; i++) cyc(1);
    cyc(6);
  endtask

  task automatic wstb(input int k, input logic [2:0] sel);
    {select_n0, select_n1, select_high2} <= sel;
    repeat (k) begin
      write_strobe_n <= 1'b0;
      cyc(3);
      write_strobe_n <= 1'b1;
      cyc(3);
    end
    cyc(4);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    error_cnt++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    reset_pin_n = 1'b1;
    low_power_hold_n = 1'b1;
    write_strobe_n = 1'b1;
    ext_low = 1'b0;
    start = 1'b0;
    nbits = 16'h0000;
    mode = 3'h7;
    {select_n0, select_n1, select_high2} = 3'h1;
    user_high_pin = 1'b0;
    user_low_pin = 1'b1;
    cyc(10);
    reset <= 1'b0;
    cyc(2);
    // Last code is not a mode and must leave the device waiting.
    for (int i = 0; i < 6; i++) begin
      boot(codes[i]);
      chk(config_clock_oe_n, 6'h30 >> i & 1);
      chk(memory_addr_oe_n, 6'h39 >> i & 1);
      chk(done_program_oe_n, 1'b0);
    end
    $display("test mode table done");
    boot(3'h7);
    chk({high_while_loading, low_while_loading, io_pullup_en, mode2_pullup_en}, 4'hB);
    frame(BITS - 2);
    chk(done_program_oe_n, 1'b0);
    frame(1);
    chk({done_program_oe_n, functional}, 2'h2);
    frame(1);
    chk(functional, 1'b1);
    chk({high_while_loading, low_while_loading, io_pullup_en}, 3'h2);
    reset_pin_n <= 1'b0;
    cyc(6);
    chk({functional, user_clear}, 2'h1);
    reset_pin_n <= 1'b1;
    cyc(6);
    chk({functional, done_program_oe_n}, 2'h3);
    low_power_hold_n <= 1'b0;
    cyc(6);
    chk({io_hiz, done_program_oe_n, user_clear}, 3'h5);
    low_power_hold_n <= 1'b1;
    cyc(6);
    chk({functional, io_hiz}, 2'h2);
    $display("test slave load done");
    ext_low <= 1'b1;
    cyc(40);
    ext_low <= 1'b0;
    cyc(6);
    chk(functional, 1'b1);
    ext_low <= 1'b1;
    cyc(90);
    ext_low <= 1'b0;
    chk(done_program_oe_n, 1'b0);
    frame(10);
    boot(3'h7);
    frame(BITS - 1);
    chk(functional, 1'b0);
    frame(1);
    chk(functional, 1'b1);
    $display("test reload done");
    for (int k = 0; k < 2; k++) begin
      ext_low <= 1'b1;
      cyc(90);
      ext_low <= (k == 1);
      boot(k ? 3'h3 : 3'h1);
      a0 = k ? 16'hFFFF : 16'h0000;
      chk(memory_addr, a0);
      for (int i = 0; i < 400 && memory_addr === a0; i++) cyc(1);
      chk(memory_addr, k ? 16'hFFFE : 16'h0001);
      a0 = memory_addr;
      for (n = 16'h0000; n < 16'h0190 && memory_addr === a0; n++) cyc(1);
      chk(n, 20 * HALF);
      cyc(300);
      chk({functional, memory_addr_oe_n}, k ? 2'h0 : 2'h3);
      a0 = memory_addr;
      cyc(45);
      chk(memory_addr === a0, k ? 1'b0 : 1'b1);
      ext_low <= 1'b0;
      cyc(8);
      chk({functional, memory_addr_oe_n}, 2'h3);
    end
    $display("test parallel done");
    ext_low <= 1'b1;
    cyc(90);
    ext_low <= 1'b0;
    boot(3'h5);
    wstb(13, 3'h5);
    wstb(13, 3'h3);
    wstb(13, 3'h0);
    wstb(BITS - 2, 3'h1);
    chk(done_program_oe_n, 1'b0);
    wstb(1, 3'h1);
    chk(done_program_oe_n, 1'b1);
    wstb(1, 3'h1);
    chk(functional, 1'b1);
    $display("test peripheral done");
    stop_test();
  end
endmodule
